// file: rtl/rxa_pkg.sv
// package: register map, field layouts and carrier structs of the rx attenuator monitor bank
package rxa_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NUM_POL = 2;
	localparam int NUM_DIODE = 8;
	// word addresses of the first instance of each register group
	localparam logic [15:0] OFS_TARGET = 16'hbb93;
	localparam logic [15:0] OFS_MAX_SEL = 16'hbb95;
	localparam logic [15:0] OFS_PRESENT = 16'hbb97;
	localparam logic [15:0] OFS_AVG = 16'hbb99;
	localparam logic [15:0] OFS_MIN = 16'hbb9b;
	localparam logic [15:0] OFS_MAX = 16'hbb9d;
	localparam logic [15:0] OFS_RAW_DRIVE = 16'hbb9f;
	localparam logic [15:0] OFS_DRV_AT_MIN = 16'hbba1;
	localparam logic [15:0] OFS_DRV_AT_MAX = 16'hbba3;
	localparam logic [15:0] OFS_DIODE = 16'hbba5;
	// own control register: loop enables and attenuator arrangement
	localparam logic [15:0] OFS_CTRL = 16'hbb8d;
	localparam int CTRL_LOOP_Y_BIT = 9;
	localparam int CTRL_LOOP_X_BIT = 10;
	localparam int CTRL_PER_POL_BIT = 0;
	localparam logic [15:0] CTRL_MASK = 16'h0601;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	// statistics minimum starts at the top so the first sample wins
	localparam logic [15:0] MIN_START = 16'hffff;
	// monitoring interval, 1 ms at 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int INTERVAL_US = 1000;
	localparam int INTERVAL_CYC = INTERVAL_US * CLK_MHZ;
	localparam logic [15:0] ACC_SHIFT = 16'h0010;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} rxa_bus_req_t;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
	} rxa_pol_pair_t;

	typedef struct packed {
		logic [15:0] avg;
		logic [15:0] min;
		logic [15:0] max;
	} rxa_stats_t;
endpackage : rxa_pkg

// file: rtl/rxa_interval_stats.sv
// module: per-interval average, minimum and maximum of one attenuation stream
`timescale 1ns/1ps
module rxa_interval_stats
	import rxa_pkg::*;
#(
	parameter int ACC_W = 48
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] sample,
	input wire logic sample_en,
	input wire logic interval_end,
	output rxa_stats_t stats
);
	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [31:0] cnt;
		logic [15:0] run_min;
		logic [15:0] run_max;
		rxa_stats_t out;
	} rxa_st_t;

	rxa_st_t st_reg;
	rxa_st_t st_next;

	function automatic logic [15:0] mean(input logic [ACC_W-1:0] a, input logic [31:0] n);
		logic [ACC_W-1:0] q;
		q = (n == 32'h0) ? '0 : a / ACC_W'(n);
		return q[15:0];
	endfunction

	// accumulate each sample; publish and restart at interval end
	always_comb begin
		st_next = st_reg;
		if (sample_en) begin
			st_next.acc = st_reg.acc + ACC_W'(sample);
			st_next.cnt = st_reg.cnt + 32'h1;
			if (sample < st_reg.run_min) st_next.run_min = sample;
			if (sample > st_reg.run_max) st_next.run_max = sample;
		end
		if (interval_end) begin
			st_next.out.avg = mean(st_next.acc, st_next.cnt);
			st_next.out.min = (st_next.cnt == 32'h0) ? RST_ZERO : st_next.run_min;
			st_next.out.max = st_next.run_max;
			st_next.acc = '0;
			st_next.cnt = 32'h0;
			st_next.run_min = MIN_START;
			st_next.run_max = RST_ZERO;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '{acc: '0, cnt: 32'h0, run_min: MIN_START, run_max: RST_ZERO,
				out: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign stats = st_reg.out;

	property p_min_le_max;
		@(posedge ref_clk) disable iff (rst)
		$rose(interval_end) |=> (st_reg.out.min <= st_reg.out.max) || (st_reg.out.min == 16'h0);
	endproperty
	a_min_le_max: assert property (p_min_le_max) else $error("interval min above max");

	property p_out_hold;
		@(posedge ref_clk) disable iff (rst)
		!interval_end |=> $stable(st_reg.out);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("stats changed mid interval");
endmodule // rxa_interval_stats

// file: rtl/rxa_sync3.sv
// module: three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rxa_sync3
	import rxa_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rxa_sy_t;

	rxa_sy_t st_reg;
	rxa_sy_t st_next;

	// s1 feeds only s2; per-bit agreement keeps glitches out
	always_comb begin
		st_next = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) st_next.q[i] = st_reg.s3[i];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;
endmodule // rxa_sync3

// file: rtl/rxa_regs.sv
// module: rx attenuator and photodiode monitor register bank
`timescale 1ns/1ps
module rxa_regs
	import rxa_pkg::*;
#(
	parameter int INTERVAL_CYCLES = INTERVAL_CYC,
	parameter logic PER_POL_DEFAULT = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	input wire rxa_pol_pair_t atten_present_in,
	input wire rxa_pol_pair_t atten_max_sel_in,
	input wire rxa_pol_pair_t drive_at_min_in,
	input wire rxa_pol_pair_t drive_at_max_in,
	input wire logic [NUM_DIODE*16-1:0] photodiode_current_in,
	output rxa_pol_pair_t atten_target,
	output rxa_pol_pair_t raw_drive,
	output logic loop_enable_x,
	output logic loop_enable_y,
	output logic per_pol_mode
);
	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [15:0] ctrl;
		rxa_pol_pair_t target;
		rxa_pol_pair_t drive;
		logic [31:0] tick;
		logic interval_end;
		logic [15:0] rdata;
		logic strap_done;
	} rxa_rg_t;

	rxa_rg_t st_reg;
	rxa_rg_t st_next;
	rxa_bus_req_t req;
	rxa_pol_pair_t present_s;
	rxa_pol_pair_t max_sel_s;
	rxa_pol_pair_t at_min_s;
	rxa_pol_pair_t at_max_s;
	logic [NUM_DIODE*16-1:0] diode_s;
	rxa_stats_t stats_x;
	rxa_stats_t stats_y;
	logic loop_any;
	logic loop_x;
	logic loop_y;

	assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

	// pair-register decode: 0 none, 1 first instance, 2 second
	function automatic logic [1:0] hit2(input logic [15:0] a, input logic [15:0] base);
		if (a == base) return 2'd1;
		if (a == base + 16'h0001) return 2'd2;
		return 2'd0;
	endfunction

	function automatic logic [15:0] pick(input logic [1:0] h, input rxa_pol_pair_t p);
		return (h == 2'd1) ? p.x : p.y;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// monitor inputs come from analog front-end logic on other timing
	rxa_sync3 #(.W(32)) u_sync_present (.ref_clk(ref_clk), .rst(rst),
		.d(atten_present_in), .q(present_s));
	rxa_sync3 #(.W(32)) u_sync_max_sel (.ref_clk(ref_clk), .rst(rst),
		.d(atten_max_sel_in), .q(max_sel_s));
	rxa_sync3 #(.W(32)) u_sync_at_min (.ref_clk(ref_clk), .rst(rst),
		.d(drive_at_min_in), .q(at_min_s));
	rxa_sync3 #(.W(32)) u_sync_at_max (.ref_clk(ref_clk), .rst(rst),
		.d(drive_at_max_in), .q(at_max_s));
	rxa_sync3 #(.W(NUM_DIODE*16)) u_sync_diode (.ref_clk(ref_clk), .rst(rst),
		.d(photodiode_current_in), .q(diode_s));

	////////////////////////////////////////////////////////////////////////////
	// loop enables; one total-power attenuator follows either bit
	assign loop_x = st_reg.ctrl[CTRL_LOOP_X_BIT];
	assign loop_y = st_reg.ctrl[CTRL_LOOP_Y_BIT];
	assign loop_any = loop_x | loop_y;
	assign per_pol_mode = st_reg.ctrl[CTRL_PER_POL_BIT];
	assign loop_enable_x = per_pol_mode ? loop_x : loop_any;
	assign loop_enable_y = per_pol_mode & loop_y;

	////////////////////////////////////////////////////////////////////////////
	// interval statistics, one engine per instance; second idle without split
	rxa_interval_stats u_stats_x (.ref_clk(ref_clk), .rst(rst), .sample(present_s.x),
		.sample_en(1'b1), .interval_end(st_reg.interval_end), .stats(stats_x));
	rxa_interval_stats u_stats_y (.ref_clk(ref_clk), .rst(rst), .sample(present_s.y),
		.sample_en(per_pol_mode), .interval_end(st_reg.interval_end),
		.stats(stats_y));

	////////////////////////////////////////////////////////////////////////////
	// register writes, read mux, interval timer
	always_comb begin
		logic [1:0] h;
		logic [15:0] di;
		h = 2'd0;
		di = RST_ZERO;
		st_next = st_reg;
		st_next.strap_done = 1'b1;
		if (!st_reg.strap_done) st_next.ctrl[CTRL_PER_POL_BIT] = PER_POL_DEFAULT;
		st_next.interval_end = 1'b0;
		if (st_reg.tick == 32'(INTERVAL_CYCLES - 1)) begin
			st_next.tick = 32'h0;
			st_next.interval_end = 1'b1;
		end else begin
			st_next.tick = st_reg.tick + 32'h1;
		end
		// writes; read-only addresses fall through untouched
		if (req.wr) begin
			if (req.addr == OFS_CTRL) st_next.ctrl = req.wdata & CTRL_MASK;
			h = hit2(req.addr, OFS_TARGET);
			if (h == 2'd1) st_next.target.x = req.wdata;
			if (h == 2'd2) st_next.target.y = req.wdata;
			h = hit2(req.addr, OFS_RAW_DRIVE);
			// drive is locked while its loop runs
			if (h == 2'd1 && !loop_enable_x) st_next.drive.x = req.wdata;
			// y locked by its own loop when split, by the single loop otherwise
			if (h == 2'd2 && !loop_enable_y && (per_pol_mode || !loop_any)) begin
				st_next.drive.y = req.wdata;
			end
		end
		// reads: data in the next cycle only, else zero
		st_next.rdata = RST_ZERO;
		if (req.rd) begin
			if (req.addr == OFS_CTRL) st_next.rdata = st_reg.ctrl;
			h = hit2(req.addr, OFS_TARGET);
			if (h != 2'd0) st_next.rdata = pick(h, st_reg.target);
			h = hit2(req.addr, OFS_MAX_SEL);
			if (h != 2'd0) st_next.rdata = pick(h, max_sel_s);
			h = hit2(req.addr, OFS_PRESENT);
			if (h != 2'd0) st_next.rdata = pick(h, present_s);
			h = hit2(req.addr, OFS_AVG);
			if (h != 2'd0) st_next.rdata = (h == 2'd1) ? stats_x.avg : stats_y.avg;
			h = hit2(req.addr, OFS_MIN);
			if (h != 2'd0) st_next.rdata = (h == 2'd1) ? stats_x.min : stats_y.min;
			h = hit2(req.addr, OFS_MAX);
			if (h != 2'd0) st_next.rdata = (h == 2'd1) ? stats_x.max : stats_y.max;
			h = hit2(req.addr, OFS_RAW_DRIVE);
			if (h != 2'd0) st_next.rdata = pick(h, st_reg.drive);
			h = hit2(req.addr, OFS_DRV_AT_MIN);
			if (h != 2'd0) st_next.rdata = pick(h, at_min_s);
			h = hit2(req.addr, OFS_DRV_AT_MAX);
			if (h != 2'd0) st_next.rdata = pick(h, at_max_s);
			for (int i = 0; i < NUM_DIODE; i++) begin
				if (req.addr == OFS_DIODE + 16'(i)) di = diode_s[i*16 +: 16];
			end
			if (req.addr >= OFS_DIODE && req.addr < OFS_DIODE + 16'(NUM_DIODE)) begin
				st_next.rdata = di;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata = st_reg.rdata;
	assign atten_target = st_reg.target;
	assign raw_drive = st_reg.drive;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_drive_locked;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_RAW_DRIVE && loop_enable_x) |=> $stable(st_reg.drive.x);
	endproperty
	a_drive_locked: assert property (p_drive_locked) else $error("drive written in loop");

	property p_drive_open;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_RAW_DRIVE && !loop_enable_x) |=> st_reg.drive.x == $past(req.wdata);
	endproperty
	a_drive_open: assert property (p_drive_open) else $error("drive write lost");

	property p_loop_either;
		@(posedge ref_clk) disable iff (rst)
		(!per_pol_mode && (loop_x || loop_y)) |-> loop_enable_x && !loop_enable_y;
	endproperty
	a_loop_either: assert property (p_loop_either) else $error("total loop enable wrong");

	property p_target_x;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_TARGET) |=> atten_target.x == $past(req.wdata);
	endproperty
	a_target_x: assert property (p_target_x) else $error("first target not written");

	property p_target_y;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_TARGET + 16'h0001) |=> atten_target.y == $past(req.wdata);
	endproperty
	a_target_y: assert property (p_target_y) else $error("second target not written");

	property p_ro_ignored;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_PRESENT) |=> $stable(st_reg.target) && $stable(st_reg.ctrl);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write had effect");

	property p_diode_read;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == OFS_DIODE) |=> bus_rdata == $past(diode_s[15:0]);
	endproperty
	a_diode_read: assert property (p_diode_read) else $error("first diode read wrong");

	property p_at_min_read;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == OFS_DRV_AT_MIN) |=> bus_rdata == $past(at_min_s.x);
	endproperty
	a_at_min_read: assert property (p_at_min_read) else $error("drive at min read wrong");

	property p_at_max_read;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == OFS_DRV_AT_MAX + 16'h0001) |=> bus_rdata == $past(at_max_s.y);
	endproperty
	a_at_max_read: assert property (p_at_max_read) else $error("drive at max read wrong");

	property p_rdata_idle;
		@(posedge ref_clk) disable iff (rst)
		!req.rd |=> bus_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

	// y drive lock follows its own loop when split, the single loop otherwise
	property p_drive_y_locked;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_RAW_DRIVE + 16'h0001
			&& (loop_enable_y || (loop_any && !per_pol_mode))) |=> $stable(st_reg.drive.y);
	endproperty
	a_drive_y_locked: assert property (p_drive_y_locked) else $error("y drive written in loop");

	property p_drive_y_open;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_RAW_DRIVE + 16'h0001 && !loop_enable_y
			&& (per_pol_mode || !loop_any)) |=> st_reg.drive.y == $past(req.wdata);
	endproperty
	a_drive_y_open: assert property (p_drive_y_open) else $error("y drive write lost");

	// the drive moves only by software-written counts, never on its own
	property p_drive_hold;
		@(posedge ref_clk) disable iff (rst)
		!(req.wr && hit2(req.addr, OFS_RAW_DRIVE) != 2'd0) |=> $stable(st_reg.drive);
	endproperty
	a_drive_hold: assert property (p_drive_hold) else $error("drive moved without write");

	property p_target_hold;
		@(posedge ref_clk) disable iff (rst)
		!(req.wr && hit2(req.addr, OFS_TARGET) != 2'd0) |=> $stable(st_reg.target);
	endproperty
	a_target_hold: assert property (p_target_hold) else $error("target moved without write");

	property p_loop_y_total;
		@(posedge ref_clk) disable iff (rst)
		!per_pol_mode |-> !loop_enable_y;
	endproperty
	a_loop_y_total: assert property (p_loop_y_total) else $error("y loop on in total mode");

	property p_loop_split;
		@(posedge ref_clk) disable iff (rst)
		per_pol_mode |-> (loop_enable_x == loop_x) && (loop_enable_y == loop_y);
	endproperty
	a_loop_split: assert property (p_loop_split) else $error("split loop enables crossed");

	property p_ctrl_write;
		@(posedge ref_clk) disable iff (rst)
		(req.wr && req.addr == OFS_CTRL) |=> st_reg.ctrl == ($past(req.wdata) & CTRL_MASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not kept");

	property p_interval_pulse;
		@(posedge ref_clk) disable iff (rst)
		st_reg.interval_end |=> !st_reg.interval_end;
	endproperty
	a_interval_pulse: assert property (p_interval_pulse) else $error("interval end stuck");

	property p_present_read;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == OFS_PRESENT) |=> bus_rdata == $past(present_s.x);
	endproperty
	a_present_read: assert property (p_present_read) else $error("present read wrong");

	property p_diode_last;
		@(posedge ref_clk) disable iff (rst)
		(req.rd && req.addr == OFS_DIODE + 16'(NUM_DIODE - 1))
			|=> bus_rdata == $past(diode_s[NUM_DIODE*16-1 -: 16]);
	endproperty
	a_diode_last: assert property (p_diode_last) else $error("last diode read wrong");
endmodule // rxa_regs

// file: dv/tb.sv
// testbench: register bank of the rx attenuator and photodiode monitor
`timescale 1ns/1ps
module tb;
	import rxa_pkg::*;
	// short monitoring interval keeps the statistics scenario brief
	localparam int IVL = 20;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic [15:0] bus_wdata = 16'h0000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [15:0] bus_rdata;
	rxa_pol_pair_t atten_present_in = '0;
	rxa_pol_pair_t atten_max_sel_in = '0;
	rxa_pol_pair_t drive_at_min_in = '0;
	rxa_pol_pair_t drive_at_max_in = '0;
	logic [NUM_DIODE*16-1:0] photodiode_current_in = '0;
	rxa_pol_pair_t atten_target;
	rxa_pol_pair_t raw_drive;
	logic loop_enable_x;
	logic loop_enable_y;
	logic per_pol_mode;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;

	rxa_regs #(.INTERVAL_CYCLES(IVL), .PER_POL_DEFAULT(1'b0)) u_rxa_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.atten_present_in(atten_present_in),
		.atten_max_sel_in(atten_max_sel_in),
		.drive_at_min_in(drive_at_min_in),
		.drive_at_max_in(drive_at_max_in),
		.photodiode_current_in(photodiode_current_in),
		.atten_target(atten_target),
		.raw_drive(raw_drive),
		.loop_enable_x(loop_enable_x),
		.loop_enable_y(loop_enable_y),
		.per_pol_mode(per_pol_mode)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #5 ref_clk = ~ref_clk;

	// whole run is a few hundred cycles, so this ceiling only trips on a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared bus and compare tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// the trailing delay lets the edge's register updates land before checks
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata, exp);
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		for (int i = 0; i < 10; i++) begin
			rchk(OFS_PRESENT + 16'(i), 16'h0000);
		end
		rchk(OFS_RAW_DRIVE + 16'h0001, 16'h0000);
		chk(raw_drive.x, 16'h0000);
		rchk(16'hbb8f, 16'h0000);
	endtask

	task automatic t_target();
		wr(OFS_TARGET, 16'h1234);
		wr(OFS_TARGET + 16'h0001, 16'hffff);
		chk(atten_target.x, 16'h1234);
		chk(atten_target.y, 16'hffff);
		rchk(OFS_TARGET, 16'h1234);
		rchk(OFS_TARGET + 16'h0001, 16'hffff);
	endtask

	// drive-at-min, drive-at-max and diodes sit at twelve adjacent addresses
	task automatic t_ro();
		@(posedge ref_clk);
		atten_max_sel_in <= '{x: 16'h0fa0, y: 16'h0bb8};
		drive_at_min_in <= '{x: 16'h1111, y: 16'h2222};
		drive_at_max_in <= '{x: 16'h3333, y: 16'h4444};
		for (int k = 0; k < NUM_DIODE; k++) begin
			photodiode_current_in[16*k +: 16] <= 16'(16'h1111 * (k + 5));
		end
		repeat (8) @(posedge ref_clk);
		rchk(OFS_MAX_SEL, 16'h0fa0);
		rchk(OFS_MAX_SEL + 16'h0001, 16'h0bb8);
		for (int i = 0; i < 12; i++) begin
			wr(OFS_DRV_AT_MIN + 16'(i), 16'h0000);
			rchk(OFS_DRV_AT_MIN + 16'(i), 16'(16'h1111 * (i + 1)));
		end
		wr(OFS_MAX_SEL, 16'h0000);
		rchk(OFS_MAX_SEL, 16'h0fa0);
	endtask

	task automatic t_drive();
		wr(OFS_RAW_DRIVE, 16'h0001);
		wr(OFS_RAW_DRIVE + 16'h0001, 16'hffff);
		chk(raw_drive.x, 16'h0001);
		chk(raw_drive.y, 16'hffff);
		// total-power arrangement: either enable turns the single loop on
		wr(OFS_CTRL, 16'h0400);
		chk({15'h0000, loop_enable_x}, 16'h0001);
		chk({15'h0000, loop_enable_y}, 16'h0000);
		wr(OFS_RAW_DRIVE, 16'h0002);
		wr(OFS_RAW_DRIVE + 16'h0001, 16'h0003);
		rchk(OFS_RAW_DRIVE, 16'h0001);
		rchk(OFS_RAW_DRIVE + 16'h0001, 16'hffff);
		wr(OFS_CTRL, 16'h0200);
		chk({15'h0000, loop_enable_x}, 16'h0001);
		wr(OFS_RAW_DRIVE, 16'h0004);
		chk(raw_drive.x, 16'h0001);
		// independent attenuators: only the Y loop is on
		wr(OFS_CTRL, 16'h0201);
		rchk(OFS_CTRL, 16'h0201);
		chk({14'h0000, loop_enable_x, per_pol_mode}, 16'h0001);
		chk({15'h0000, loop_enable_y}, 16'h0001);
		wr(OFS_RAW_DRIVE, 16'h0005);
		wr(OFS_RAW_DRIVE + 16'h0001, 16'h0006);
		chk(raw_drive.x, 16'h0005);
		chk(raw_drive.y, 16'hffff);
		// split attenuators, only the X loop on: Y drive stays writable
		wr(OFS_CTRL, 16'h0401);
		wr(OFS_RAW_DRIVE, 16'h0007);
		wr(OFS_RAW_DRIVE + 16'h0001, 16'h0008);
		chk(raw_drive.x, 16'h0005);
		chk(raw_drive.y, 16'h0008);
		chk({15'h0000, loop_enable_y}, 16'h0000);
	endtask

	// a steady input makes average, minimum and maximum all equal to it
	task automatic t_stats();
		wr(OFS_CTRL, 16'h0001);
		@(posedge ref_clk);
		atten_present_in <= '{x: 16'h0123, y: 16'h0456};
		repeat (4 * IVL + 10) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rchk(OFS_PRESENT + 16'(2 * i), 16'h0123);
			rchk(OFS_PRESENT + 16'(2 * i + 1), 16'h0456);
		end
		wr(OFS_AVG, 16'h0000);
		rchk(OFS_AVG, 16'h0123);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_target();
		t_ro();
		t_drive();
		t_stats();
		end_of_test();
	end
endmodule // tb
